//--- core/hmsp_pkg.sv
/*
 * constants for the host modem serial ports: register map, field layout,
 * reset values, baud divisors and boot trace table.
 * assumes a 10 MHz system clock and a 32-bit apb master.
 */
// Overview of operation
// - three ports, each with optional rts/cts flow
// - host modem port: commands, 115200, 8n1, flow
// - debug port: debug, 921600, 8n1, flow, boot trace
// - console port: console, 115200, 8n1, no flow
// - host sends into in_data, module drives out_data
// - primary request line wakes module from low power
// - primary clear_to_send shows module ready to receive
// - deep sleep releases primary clear_to_send drive
// - debug request line also wakes the module
// - console lines never wake the module
// - each port usage mode set by software
package hmsp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_CMD = 115200;
    localparam int BAUD_DBG = 921600;
    localparam int DIV_W = 16;
    // rounded cycles per bit
    localparam logic [DIV_W-1:0] DIV_CMD = DIV_W'((CLK_HZ + BAUD_CMD / 2) / BAUD_CMD);
    localparam logic [DIV_W-1:0] DIV_DBG = DIV_W'((CLK_HZ + BAUD_DBG / 2) / BAUD_DBG);
    localparam logic [3:0] FRAME_BITS = 4'h9;
    localparam logic [2:0] DATA_BITS = 3'h7;
    // register map: port n at n*0x10, power at 0x30
    localparam logic [1:0] REG_CFG = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] PORT_PWR = 2'h3;
    localparam int CFG_FLOW = 16;
    localparam int CFG_MODE = 17;
    localparam int ST_RXV = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_OVR = 2;
    localparam int ST_FERR = 3;
    localparam int ST_RTS = 4;
    localparam int PW_LOW = 0;
    localparam int PW_DEEP = 1;
    localparam int PW_WAKE = 2;
    typedef enum logic [1:0] {HMSP_HOST_CMD, HMSP_DEBUG, HMSP_CONSOLE} hmsp_mode_t;
    localparam logic [2:0] FLOW_RST = 3'h3;
    localparam int BOOT_LEN = 6;
    // boot trace text "BOOT" cr lf
    function automatic logic [7:0] hmsp_boot_byte(input logic [2:0] i);
        case (i)
            3'h0: return 8'h42;
            3'h1: return 8'h4f;
            3'h2: return 8'h4f;
            3'h3: return 8'h54;
            3'h4: return 8'h0d;
            default: return 8'h0a;
        endcase
    endfunction
endpackage

//--- core/hmsp_chan_if.sv
/*
 * carrier between the register core and one serial channel.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface hmsp_chan_if #(parameter int DIV_W = 16);
    logic [DIV_W-1:0] div;
    logic flow_en;
    logic [7:0] tx_data;
    logic tx_start;
    logic tx_busy;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_read;
    logic overrun;
    logic frame_err;
    logic [1:0] err_clr;
    logic rts_active;
    modport core (output div, flow_en, tx_data, tx_start, rx_read, err_clr,
        input tx_busy, rx_data, rx_valid, overrun, frame_err, rts_active);
    modport chan (input div, flow_en, tx_data, tx_start, rx_read, err_clr,
        output tx_busy, rx_data, rx_valid, overrun, frame_err, rts_active);
endinterface

//--- core/hmsp_uart_chan.sv
/*
 * one serial channel: transmitter, receiver, flow lines.
 * assumes pins are asynchronous to clk; synchronised here.
 */
`timescale 1ns/1ps
module hmsp_uart_chan import hmsp_pkg::*; #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_data,
    input wire logic req_line,
    output logic out_data,
    output logic clear_n,
    hmsp_chan_if.chan bus
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} hmsp_rx_t;
    logic [1:0] rx_meta, rts_meta;
    logic rx_s, rts_s;
    logic tx_pend, tx_act;
    logic [7:0] tx_hold;
    logic [9:0] tx_sh;
    logic [DIV_W-1:0] tx_cnt, rx_cnt;
    logic [3:0] tx_bits;
    logic [2:0] rx_bits;
    logic [7:0] rx_sh;
    hmsp_rx_t rx_st;
    logic rx_tick, deliver, bad_stop;

    if (DIV_W < 4) begin : g_chk
        $error("divisor width too small");
    end

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_meta <= 2'h3;
            rts_meta <= 2'h3;
        end else begin
            rx_meta <= {rx_meta[0], in_data};
            rts_meta <= {rts_meta[0], req_line};
        end
    end
    assign rx_s = rx_meta[1];
    assign rts_s = rts_meta[1];
    assign bus.rts_active = ~rts_s; // active low

    ////////////////////////////////////////////////////////////////////
    // transmitter: waits for host request when flow is on
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_pend <= 1'b0;
            tx_act <= 1'b0;
            tx_hold <= 8'h00;
            tx_sh <= 10'h3ff;
            tx_cnt <= '0;
            tx_bits <= 4'h0;
        end else if (!tx_act) begin
            if (bus.tx_start && !tx_pend) begin
                tx_pend <= 1'b1;
                tx_hold <= bus.tx_data;
            end else if (tx_pend && (!bus.flow_en || !rts_s)) begin
                tx_pend <= 1'b0;
                tx_act <= 1'b1;
                tx_sh <= {1'b1, tx_hold, 1'b0};
                tx_cnt <= bus.div - 1'b1;
                tx_bits <= FRAME_BITS;
            end
        end else if (tx_cnt == '0) begin
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_cnt <= bus.div - 1'b1;
            tx_act <= (tx_bits != 4'h0);
            tx_bits <= tx_bits - 1'b1;
        end else begin
            tx_cnt <= tx_cnt - 1'b1;
        end
    end
    assign out_data = tx_sh[0];
    assign bus.tx_busy = tx_pend | tx_act;

    ////////////////////////////////////////////////////////////////////
    // receiver: mid-bit sampling, lsb first
    assign rx_tick = (rx_cnt == '0);
    assign deliver = (rx_st == RX_STOP) && rx_tick && rx_s;
    assign bad_stop = (rx_st == RX_STOP) && rx_tick && !rx_s;
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_st <= RX_IDLE;
            rx_cnt <= '0;
            rx_bits <= 3'h0;
            rx_sh <= 8'h00;
        end else begin
            rx_cnt <= rx_tick ? bus.div - 1'b1 : rx_cnt - 1'b1;
            case (rx_st)
                RX_IDLE: begin
                    if (!rx_s) begin
                        rx_st <= RX_START;
                        rx_cnt <= bus.div >> 1;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_st <= rx_s ? RX_IDLE : RX_DATA;
                        rx_bits <= DATA_BITS;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh <= {rx_s, rx_sh[7:1]};
                        rx_bits <= rx_bits - 1'b1;
                        if (rx_bits == 3'h0) begin
                            rx_st <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_st <= RX_IDLE;
                    end
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // holding register and sticky errors, set beats clear
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.rx_valid <= 1'b0;
            bus.rx_data <= 8'h00;
            bus.overrun <= 1'b0;
            bus.frame_err <= 1'b0;
        end else begin
            if (deliver && (!bus.rx_valid || bus.rx_read)) begin
                bus.rx_data <= rx_sh;
                bus.rx_valid <= 1'b1;
            end else if (bus.rx_read) begin
                bus.rx_valid <= 1'b0;
            end
            if (deliver && bus.rx_valid && !bus.rx_read) begin
                bus.overrun <= 1'b1;
            end else if (bus.err_clr[0]) begin
                bus.overrun <= 1'b0;
            end
            if (bad_stop) begin
                bus.frame_err <= 1'b1;
            end else if (bus.err_clr[1]) begin
                bus.frame_err <= 1'b0;
            end
        end
    end

    // clear to send low while the holding register is free
    assign clear_n = bus.flow_en & bus.rx_valid;
endmodule

//--- core/hmsp_top.sv
/*
 * host modem serial ports: three channels, apb registers, wake logic
 * and boot trace on the debug port.
 * assumes a 10 MHz clk, synchronous active-high rst, zero-wait apb.
 */
`timescale 1ns/1ps
module hmsp_top import hmsp_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int BAUD_DIV_W = DIV_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_port_in_data,
    output logic primary_port_out_data,
    input wire logic primary_port_wake_request,
    output logic primary_port_clear_to_send,
    output logic primary_port_clear_to_send_oe,
    input wire logic debug_port_in_data,
    output logic debug_port_out_data,
    input wire logic debug_port_wake_request,
    output logic debug_port_clear_to_send,
    input wire logic console_port_in_data,
    output logic console_port_out_data,
    input wire logic console_port_request_line,
    output logic console_port_clear_line,
    output logic low_power
);
    logic [2:0] pin_in, pin_req, pin_out, pin_clr;
    logic [BAUD_DIV_W-1:0] div_r [3];
    logic [2:0] flow_r;
    hmsp_mode_t mode_r [3];
    logic [2:0] rxv_v, busy_v, ovr_v, ferr_v, rts_v;
    logic [7:0] rxd_v [3];
    logic [2:0] start_v, read_v;
    logic [7:0] txd_v [3];
    logic [1:0] clr_v [3];
    logic deep_sleep, wake_seen, wake_req;
    logic boot_act, boot_go;
    logic [2:0] boot_idx;
    logic wr_en, rd_en, acc_ok;
    logic [1:0] a_port, a_reg;
    logic [31:0] next_prdata;

    if (ADDR_W < 7 || BAUD_DIV_W < 8 || BAUD_DIV_W > CFG_FLOW) begin : g_chk
        $error("unsupported address or divisor width");
    end

    ////////////////////////////////////////////////////////////////////
    // pin bundling, one index per port
    assign pin_in = {console_port_in_data, debug_port_in_data, primary_port_in_data};
    assign pin_req = {console_port_request_line, debug_port_wake_request,
        primary_port_wake_request};
    assign primary_port_out_data = pin_out[0];
    assign debug_port_out_data = pin_out[1];
    assign console_port_out_data = pin_out[2];
    assign primary_port_clear_to_send = pin_clr[0];
    assign primary_port_clear_to_send_oe = ~deep_sleep;
    assign debug_port_clear_to_send = pin_clr[1];
    assign console_port_clear_line = pin_clr[2];

    ////////////////////////////////////////////////////////////////////
    // channels, one per port
    hmsp_chan_if #(.DIV_W(BAUD_DIV_W)) ch [3] ();
    for (genvar i = 0; i < 3; i++) begin : g_ch
        assign ch[i].div = div_r[i];
        assign ch[i].flow_en = flow_r[i];
        assign ch[i].tx_data = txd_v[i];
        assign ch[i].tx_start = start_v[i];
        assign ch[i].rx_read = read_v[i];
        assign ch[i].err_clr = clr_v[i];
        assign rxv_v[i] = ch[i].rx_valid;
        assign busy_v[i] = ch[i].tx_busy;
        assign ovr_v[i] = ch[i].overrun;
        assign ferr_v[i] = ch[i].frame_err;
        assign rts_v[i] = ch[i].rts_active;
        assign rxd_v[i] = ch[i].rx_data;
        hmsp_uart_chan #(.DIV_W(BAUD_DIV_W)) u_chan (
            .clk(clk),
            .rst(rst),
            .in_data(pin_in[i]),
            .req_line(pin_req[i]),
            .out_data(pin_out[i]),
            .clear_n(pin_clr[i]),
            .bus(ch[i])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // address decode shared by read and write paths
    function automatic logic [3:0] dec(input logic [ADDR_W-1:0] a);
        return {a[5:4], a[3:2]};
    endfunction
    function automatic logic hit(input logic [ADDR_W-1:0] a);
        logic [3:0] d;
        d = dec(a);
        if (a[1:0] != 2'h0 || a[ADDR_W-1:6] != '0) begin
            return 1'b0;
        end
        if (d[3:2] == PORT_PWR) begin
            return d[1:0] == REG_CFG;
        end
        return d[1:0] != 2'h3;
    endfunction

    assign {a_port, a_reg} = dec(paddr);
    assign acc_ok = hit(paddr);
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~acc_ok;
    assign wr_en = psel & penable & pwrite & acc_ok;
    assign rd_en = psel & penable & ~pwrite & acc_ok;

    ////////////////////////////////////////////////////////////////////
    // per-port configuration: divisor, flow, usage mode
    always_ff @(posedge clk) begin
        if (rst) begin
            div_r[0] <= BAUD_DIV_W'(DIV_CMD);
            div_r[1] <= BAUD_DIV_W'(DIV_DBG);
            div_r[2] <= BAUD_DIV_W'(DIV_CMD);
            flow_r <= FLOW_RST;
            mode_r[0] <= HMSP_HOST_CMD;
            mode_r[1] <= HMSP_DEBUG;
            mode_r[2] <= HMSP_CONSOLE;
        end else if (wr_en && a_port != PORT_PWR && a_reg == REG_CFG) begin
            div_r[a_port] <= pwdata[BAUD_DIV_W-1:0];
            flow_r[a_port] <= pwdata[CFG_FLOW];
            mode_r[a_port] <= hmsp_mode_t'(pwdata[CFG_MODE+:2]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit, receive-pop and error-clear strobes
    always_comb begin
        start_v = 3'h0;
        read_v = 3'h0;
        for (int i = 0; i < 3; i++) begin
            txd_v[i] = pwdata[7:0];
            clr_v[i] = 2'h0;
            if (a_port == 2'(i)) begin
                start_v[i] = wr_en && a_reg == REG_DATA;
                read_v[i] = rd_en && a_reg == REG_DATA;
                if (wr_en && a_reg == REG_STAT) begin
                    clr_v[i] = {pwdata[ST_FERR], pwdata[ST_OVR]};
                end
            end
        end
        if (boot_act) begin
            start_v[1] = boot_go;
            txd_v[1] = hmsp_boot_byte(boot_idx);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // boot trace sequencer on the debug port
    assign boot_go = boot_act && !busy_v[1] && mode_r[1] == HMSP_DEBUG;
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_act <= 1'b1;
            boot_idx <= 3'h0;
        end else if (boot_act && mode_r[1] != HMSP_DEBUG) begin
            boot_act <= 1'b0;
        end else if (boot_go) begin
            boot_idx <= boot_idx + 1'b1;
            boot_act <= (boot_idx != 3'(BOOT_LEN - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // low power state and wake from host request lines
    assign wake_req = rts_v[0] | rts_v[1];
    always_ff @(posedge clk) begin
        if (rst) begin
            low_power <= 1'b0;
            deep_sleep <= 1'b0;
            wake_seen <= 1'b0;
        end else begin
            if (low_power && wake_req) begin
                low_power <= 1'b0;
                deep_sleep <= 1'b0;
            end else if (wr_en && a_port == PORT_PWR) begin
                low_power <= pwdata[PW_LOW] | pwdata[PW_DEEP];
                deep_sleep <= pwdata[PW_DEEP];
            end
            if (low_power && wake_req) begin
                wake_seen <= 1'b1;
            end else if (wr_en && a_port == PORT_PWR && pwdata[PW_WAKE]) begin
                wake_seen <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data captured in the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (a_port == PORT_PWR) begin
            next_prdata[PW_LOW] = low_power;
            next_prdata[PW_DEEP] = deep_sleep;
            next_prdata[PW_WAKE] = wake_seen;
        end else begin
            case (a_reg)
                REG_CFG: begin
                    next_prdata[BAUD_DIV_W-1:0] = div_r[a_port];
                    next_prdata[CFG_FLOW] = flow_r[a_port];
                    next_prdata[CFG_MODE+:2] = mode_r[a_port];
                end
                REG_STAT: begin
                    next_prdata[ST_RXV] = rxv_v[a_port];
                    next_prdata[ST_BUSY] = busy_v[a_port] | (a_port == 2'h1 && boot_act);
                    next_prdata[ST_OVR] = ovr_v[a_port];
                    next_prdata[ST_FERR] = ferr_v[a_port];
                    next_prdata[ST_RTS] = rts_v[a_port];
                end
                REG_DATA: next_prdata[7:0] = rxd_v[a_port];
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (!hit(paddr)) begin
            next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end
endmodule

//--- sim/hmsp_host_model.sv
/*
 * host side of one serial port: sends frames, collects frames.
 * assumes the module clock and a bit length of DIV cycles.
 */
`timescale 1ns/1ps
module hmsp_host_model #(
    parameter int DIV = 87
) (
    input wire logic clk,
    input wire logic dev_out,
    input wire logic dev_cts_n,
    output logic dev_in
);
    logic [7:0] q[$];
    logic [7:0] rx_b;
    // idle high between frames
    initial dev_in = 1'b1;
    // collect frames: start low, lsb first, stop high
    always begin
        @(negedge dev_out);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            rx_b[i] = dev_out;
        end
        repeat (DIV) @(posedge clk);
        if (dev_out === 1'b1) q.push_back(rx_b);
    end
    // send one frame once the module is ready
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        while (dev_cts_n !== 1'b0) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            dev_in <= f[i];
            repeat (DIV) @(posedge clk);
        end
    endtask
endmodule

//--- sim/hmsp_top_checker.sv
/*
 * assertions on apb answer, idle levels, wake and deep sleep.
 * assumes it is bound into hmsp_top and sees only its ports.
 */
`timescale 1ns/1ps
module hmsp_top_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic primary_port_out_data,
    input wire logic primary_port_wake_request,
    input wire logic primary_port_clear_to_send_oe,
    input wire logic debug_port_out_data,
    input wire logic debug_port_wake_request,
    input wire logic console_port_out_data,
    input wire logic low_power
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // apb answers at once, refuses unaligned words
    ready_at_once_a: assert property (
        psel && penable |-> pready)
        else $error("no ready in access phase");
    unaligned_err_a: assert property (
        psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("no error on unaligned address");
    // serial lines idle high, start bit lasts
    idle_high_a: assert property (
        $fell(rst) |-> primary_port_out_data && debug_port_out_data && console_port_out_data)
        else $error("serial output not idle after reset");
    start_bit_a: assert property (
        $fell(debug_port_out_data) |-> !debug_port_out_data [*8])
        else $error("start bit too short");
    // clear_to_send driven whenever awake
    oe_awake_a: assert property (
        !low_power |-> primary_port_clear_to_send_oe)
        else $error("clear_to_send released while awake");
    // wake sources and the console that is not one
    primary_wake_a: assert property (
        (low_power && !primary_port_wake_request) [*3] |-> ##[1:2] !low_power)
        else $error("primary request did not wake");
    debug_wake_a: assert property (
        (low_power && !debug_port_wake_request) [*3] |-> ##[1:2] !low_power)
        else $error("debug request did not wake");
    console_no_wake_a: assert property (
        (low_power && primary_port_wake_request && debug_port_wake_request && !psel) [*3]
        |=> low_power)
        else $error("woke without a wake request");
endmodule
bind hmsp_top hmsp_top_checker #(.ADDR_W(ADDR_W)) hmsp_top_checker_inst (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .primary_port_out_data(primary_port_out_data),
    .primary_port_wake_request(primary_port_wake_request),
    .primary_port_clear_to_send_oe(primary_port_clear_to_send_oe),
    .debug_port_out_data(debug_port_out_data),
    .debug_port_wake_request(debug_port_wake_request),
    .console_port_out_data(console_port_out_data), .low_power(low_power));

//--- sim/hmsp_top_tb.sv
/*
 * testbench for the serial ports: register table, boot trace,
 * traffic both ways, low power and wake.
 * assumes a host model on each port and the bound checker.
 */
`timescale 1ns/1ps
module hmsp_top_tb import hmsp_pkg::*;;
    typedef struct {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic err;
    } hmsp_row_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, er, low_power;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pri_in, pri_out, pri_req_n, pri_cts_n, pri_oe, pri_wire_n;
    logic dbg_in, dbg_out, dbg_req_n, dbg_cts_n, con_in, con_out, con_req_n, con_cts_n;
    int err_total, cmp_count;
    hmsp_row_t rows[10];
    logic [7:0] boot[6];
    // released clear_to_send floats up to the pull-up
    assign pri_wire_n = pri_oe ? pri_cts_n : 1'b1;
    hmsp_top hmsp_top_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_port_in_data(pri_in),
        .primary_port_out_data(pri_out), .primary_port_wake_request(pri_req_n),
        .primary_port_clear_to_send(pri_cts_n), .primary_port_clear_to_send_oe(pri_oe),
        .debug_port_in_data(dbg_in), .debug_port_out_data(dbg_out),
        .debug_port_wake_request(dbg_req_n), .debug_port_clear_to_send(dbg_cts_n),
        .console_port_in_data(con_in), .console_port_out_data(con_out),
        .console_port_request_line(con_req_n), .console_port_clear_line(con_cts_n),
        .low_power(low_power));
    hmsp_host_model #(.DIV(int'(DIV_CMD))) hmsp_host_model_inst0 (.clk(clk),
        .dev_out(pri_out), .dev_cts_n(pri_wire_n), .dev_in(pri_in));
    hmsp_host_model #(.DIV(int'(DIV_DBG))) hmsp_host_model_inst1 (.clk(clk),
        .dev_out(dbg_out), .dev_cts_n(dbg_cts_n), .dev_in(dbg_in));
    hmsp_host_model #(.DIV(int'(DIV_CMD))) hmsp_host_model_inst2 (.clk(clk),
        .dev_out(con_out), .dev_cts_n(con_cts_n), .dev_in(con_in));
    ////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // compare, count, report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic int qsize(input int k);
        case (k)
            0: return hmsp_host_model_inst0.q.size();
            1: return hmsp_host_model_inst1.q.size();
            default: return hmsp_host_model_inst2.q.size();
        endcase
    endfunction
    task automatic wait_q(input int k, input int n);
        while (qsize(k) < n) @(posedge clk);
    endtask
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #2_000_000;
        err_total++;
        end_sim();
    end
    ////////////////////////////////////////
    // main sequence
    initial begin
        err_total = 0;
        cmp_count = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pri_req_n = 1'b1;
        dbg_req_n = 1'b0;
        con_req_n = 1'b1;
        boot = '{8'h42, 8'h4f, 8'h4f, 8'h54, 8'h0d, 8'h0a};
        rows = '{
            '{1'b0, 8'h00, 32'h0000_0000, {13'h0000, 2'h0, 1'b1, DIV_CMD}, 1'b0},
            '{1'b0, 8'h10, 32'h0000_0000, {13'h0000, 2'h1, 1'b1, DIV_DBG}, 1'b0},
            '{1'b0, 8'h20, 32'h0000_0000, {13'h0000, 2'h2, 1'b0, DIV_CMD}, 1'b0},
            '{1'b0, 8'h30, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b1, 8'h20, {13'h0000, 2'h0, 1'b1, DIV_CMD}, 32'h0000_0000, 1'b0},
            '{1'b0, 8'h20, 32'h0000_0000, {13'h0000, 2'h0, 1'b1, DIV_CMD}, 1'b0},
            '{1'b0, 8'h3c, 32'h0000_0000, 32'h0000_0000, 1'b1},
            '{1'b1, 8'h22, 32'h0000_ffff, 32'h0000_0000, 1'b1},
            '{1'b0, 8'h0c, 32'h0000_0000, 32'h0000_0000, 1'b1}};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data, rd, er);
            chk(32'(er), 32'(rows[i].err));
            if (!rows[i].wr) chk(rd, rows[i].exp);
        end
        chk(32'({dbg_cts_n, con_cts_n}), 32'h0000_0000);
        // boot trace on the debug port
        wait_q(1, 6);
        for (int i = 0; i < 6; i++) begin
            chk(32'(hmsp_host_model_inst1.q[i]), 32'(boot[i]));
        end
        // mid-run reset restores console settings
        dbg_req_n <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h20, 32'h0000_0000, rd, er);
        chk(rd, {13'h0000, 2'h2, 1'b0, DIV_CMD});
        // idle host request holds a byte back
        apb(1'b1, 8'h08, 32'h0000_005a, rd, er);
        repeat (2 * DIV_CMD) @(posedge clk);
        chk(32'(qsize(0)), 32'h0000_0000);
        pri_req_n <= 1'b0;
        wait_q(0, 1);
        chk(32'(hmsp_host_model_inst0.q[0]), 32'h0000_005a);
        pri_req_n <= 1'b1;
        // received byte held with clear_to_send off
        hmsp_host_model_inst0.send(8'ha5);
        repeat (4) @(posedge clk);
        chk(32'(pri_wire_n), 32'h0000_0001);
        apb(1'b0, 8'h04, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 8'h08, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_00a5);
        repeat (2) @(posedge clk);
        chk(32'(pri_wire_n), 32'h0000_0000);
        // console sends with its request line idle
        apb(1'b1, 8'h28, 32'h0000_003c, rd, er);
        wait_q(2, 1);
        chk(32'(hmsp_host_model_inst2.q[0]), 32'h0000_003c);
        // deep sleep, console activity, wake by each request
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h30, 32'h0000_0003, rd, er);
            repeat (2) @(posedge clk);
            chk(32'(pri_oe), 32'h0000_0000);
            if (k == 0) begin
                con_req_n <= 1'b0;
                hmsp_host_model_inst2.send(8'h11);
                chk(32'(low_power), 32'h0000_0001);
                con_req_n <= 1'b1;
                pri_req_n <= 1'b0;
            end else begin
                dbg_req_n <= 1'b0;
            end
            repeat (4) @(posedge clk);
            chk(32'(low_power), 32'h0000_0000);
            apb(1'b0, 8'h30, 32'h0000_0000, rd, er);
            chk(rd, 32'h0000_0004);
            pri_req_n <= 1'b1;
            dbg_req_n <= 1'b1;
        end
        // console overrun
        hmsp_host_model_inst2.send(8'h22);
        apb(1'b0, 8'h24, 32'h0000_0000, rd, er);
        chk(rd, 32'h0000_0005);
        end_sim();
    end
endmodule
